/* File: src/acr_frame_shift.sv */
// Serial frame receiver: collects 24-bit frames on shift clock edges
`timescale 1ns/100ps
module acr_frame_shift (
  input  wire logic                        mclk,
  input  wire logic                        resetn,
  input  wire logic                        shiftClockRise,
  input  wire logic                        frameSelectN,
  input  wire logic                        shiftIn,
  output logic [acr_pkg::FRAME_W-2:0]      partial,
  output logic [acr_pkg::CNT_W-1:0]        bitCount,
  output logic                             frameDone,
  output logic [acr_pkg::FRAME_W-1:0]      frameWord
);
  logic [acr_pkg::FRAME_W-2:0] shift_q, shift_d; // Bits gathered so far
  logic [acr_pkg::CNT_W-1:0]   cnt_q, cnt_d;     // Position in frame
  logic                        done_q, done_d;   // Frame complete pulse
  logic [acr_pkg::FRAME_W-1:0] word_q, word_d;   // Last full frame

  // Next-state: counter restarts on each deselect, groups of 24
  always_comb begin
    shift_d = shift_q;
    cnt_d   = cnt_q;
    done_d  = 1'b0;
    word_d  = word_q;
    if (frameSelectN) begin
      // Partial frames are dropped when select rises
      cnt_d = '0;
    end else if (shiftClockRise) begin // [RULE21]
      if (cnt_q == acr_pkg::LAST_BIT) begin // [RULE20]
        word_d = {shift_q, shiftIn};
        done_d = 1'b1;
        cnt_d  = '0;
      end else begin
        shift_d = {shift_q[acr_pkg::FRAME_W-3:0], shiftIn};
        cnt_d   = cnt_q + 5'h01;
      end
    end
  end

  // Registers only
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      shift_q <= '0;
      cnt_q   <= '0;
      done_q  <= 1'b0;
      word_q  <= '0;
    end else begin
      shift_q <= shift_d;
      cnt_q   <= cnt_d;
      done_q  <= done_d;
      word_q  <= word_d;
    end
  end

  assign partial   = shift_q;
  assign bitCount  = cnt_q;
  assign frameDone = done_q;
  assign frameWord = word_q;
endmodule // acr_frame_shift

/* File: src/acr_pkg.sv */
// Package with register map, field positions and frame constants
// Operation
// [RULE1] Reset pin pulse restores register defaults
// [RULE2] Init bit loads zeros, then self-clears
// [RULE3] Host may keep reset pin low
// [RULE4] All registers default to zero
// [RULE5] Host writes zero to unlisted bits
// [RULE6] Demodulator reset via its register bit; this bank has no demodulator reset bit
// [RULE7] Register zero write-only, init and readback
// [RULE8] Readback select turns frames into reads
// [RULE9] Full sleep; host reloads demodulator afterwards
// [RULE10] Serial output off disables data lanes
// [RULE11] Per-channel converter power-down bits
// [RULE12] Light sleep gives partial power-down
// [RULE13] Slow noise reject enables suppression
// [RULE14] Outside voltage source selects external reference
// [RULE15] Pair sharing doubles lane rate
// [RULE16] One-wire clock input selects single-ended
// [RULE17] Per-lane driver power-down bits
// [RULE18] Channel pair mean averages two channels
// [RULE19] Fast path bypass lowers latency
// [RULE20] Frame is 8 address, 16 data bits
// [RULE21] Sample on rising shift clock, select low
// [RULE22] Undefined bits read back as zero
package acr_pkg;
  localparam int ADDR_W = 8;               // Address field width
  localparam int DATA_W = 16;              // Data field width
  localparam int FRAME_W = ADDR_W + DATA_W; // Whole frame width
  localparam int CNT_W = 5;                // Bit counter width
  localparam logic [CNT_W-1:0] LAST_BIT = 5'h17; // Index of 24th bit

  localparam logic [ADDR_W-1:0] ADDR_CTRL  = 8'h00; // Init/readback
  localparam logic [ADDR_W-1:0] ADDR_PWR   = 8'h01; // Power/ref/clock
  localparam logic [ADDR_W-1:0] ADDR_LANE  = 8'h02; // Lane/avg/latency
  localparam logic [DATA_W-1:0] REG_RESET  = 16'h0000; // All defaults

  // Register 0 fields
  localparam int B_INIT = 0;
  localparam int B_RDSEL = 1;
  // Register 1 fields
  localparam int B_FULL_SLEEP = 0;
  localparam int B_SEROUT_OFF = 1;
  localparam int B_CHOFF_LO = 2;
  localparam int B_LIGHT_SLEEP = 10;
  localparam int B_SLOW_NR = 11;
  localparam int B_OUTSIDE_REF = 13;
  localparam int B_PAIR_SHARE = 14;
  localparam int B_ONE_WIRE_CLK = 15;
  // Register 2 fields
  localparam int B_LANEOFF_LO = 3;
  localparam int B_PAIR_MEAN = 11;
  localparam int B_FAST_PATH = 12;
  localparam int NCH = 8;                  // Channel count
  // Defined-bit masks for readback
  localparam logic [DATA_W-1:0] MASK_PWR  = 16'hefff;
  localparam logic [DATA_W-1:0] MASK_LANE = 16'h1ff8;
endpackage : acr_pkg

/* File: src/acr_read_out.sv */
// Readback shifter: sends 16 data bits MSB first, MSB at address end, the rest on falling shift clock
`timescale 1ns/100ps
module acr_read_out (
  input  wire logic                        mclk,
  input  wire logic                        resetn,
  input  wire logic                        shiftClockFall,
  input  wire logic                        load,
  input  wire logic [acr_pkg::DATA_W-1:0]  loadData,
  input  wire logic                        enable,
  output logic                             dataOut,
  output logic                             dataOutEnN
);
  logic [acr_pkg::DATA_W-1:0] sh_q, sh_d;  // Outgoing word
  logic                       out_q, out_d; // Bit on the pin
  logic                       en_q, en_d;   // Pin driven when low

  // Load at address end, shift each falling edge afterwards
  always_comb begin
    sh_d  = sh_q;
    out_d = out_q;
    en_d  = ~enable;
    if (load) begin
      out_d = loadData[acr_pkg::DATA_W-1];
      sh_d  = {loadData[acr_pkg::DATA_W-2:0], 1'b0};
    end else if (shiftClockFall) begin
      out_d = sh_q[acr_pkg::DATA_W-1];
      sh_d  = {sh_q[acr_pkg::DATA_W-2:0], 1'b0};
    end
  end

  // Registers only
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sh_q  <= '0;
      out_q <= 1'b0;
      en_q  <= 1'b1;
    end else begin
      sh_q  <= sh_d;
      out_q <= out_d;
      en_q  <= en_d;
    end
  end

  assign dataOut    = out_q;
  assign dataOutEnN = en_q;
endmodule // acr_read_out

/* File: src/acr_top.sv */
// Converter control register bank behind the three-wire serial port
`timescale 1ns/100ps
module acr_top (
  input  wire logic                    mclk,
  input  wire logic                    resetn,
  input  wire logic                    resetPin,
  input  wire logic                    shiftClock,
  input  wire logic                    frameSelectN,
  input  wire logic                    shiftIn,
  output logic                         serialReadOut,
  output logic                         serialReadOutEnN,
  output logic                         fullSleep,
  output logic                         serialOutOff,
  output logic [acr_pkg::NCH-1:0]      perChannelConverterOff,
  output logic                         lightSleep,
  output logic                         slowNoiseReject,
  output logic                         outsideVoltageSource,
  output logic                         pairSharing,
  output logic                         oneWireClockInput,
  output logic [acr_pkg::NCH-1:0]      perLaneDriverOff,
  output logic                         channelPairMean,
  output logic                         fastPathBypass,
  output logic                         readbackSelect
);
  typedef enum logic [1:0] {
    ACR_RUN  = 2'b01, // Normal register access
    ACR_INIT = 2'b10  // Software init in progress
  } acr_state_t;

  acr_state_t                 st_q, st_d;     // Init sequencer
  logic [acr_pkg::DATA_W-1:0] ctrl_q, ctrl_d; // Register 0
  logic [acr_pkg::DATA_W-1:0] pwr_q, pwr_d;   // Register 1
  logic [acr_pkg::DATA_W-1:0] lane_q, lane_d; // Register 2
  logic                       sclk_q;         // Shift clock history
  logic                       rstPin_q;       // Reset pin history
  logic                       sclkRise;       // Rising shift edge
  logic                       sclkFall;       // Falling shift edge
  logic                       pinPulse;       // Reset pin falling edge
  logic [acr_pkg::FRAME_W-2:0] partial;       // Bits collected so far
  logic [acr_pkg::CNT_W-1:0]  bitCount;       // Position in frame
  logic                       frameDone;      // Full frame arrived
  logic [acr_pkg::FRAME_W-1:0] frameWord;     // The frame itself
  logic [acr_pkg::ADDR_W-1:0] wrAddr;         // Frame address
  logic [acr_pkg::DATA_W-1:0] wrData;         // Frame data
  logic [acr_pkg::ADDR_W-1:0] rdAddr;         // Address for readback
  logic [acr_pkg::DATA_W-1:0] rdData;         // Readback value
  logic                       rdLoad;         // Address just complete

  // Edge history; inputs are synchronous to mclk
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sclk_q   <= 1'b0;
      rstPin_q <= 1'b0;
    end else begin
      sclk_q   <= shiftClock;
      rstPin_q <= resetPin;
    end
  end

  assign sclkRise = shiftClock & ~sclk_q;
  assign sclkFall = ~shiftClock & sclk_q;
  // Reset acts at end of the positive pulse so it is never partial
  assign pinPulse = rstPin_q & ~resetPin;

  // Frame receiver
  acr_frame_shift u_shift (
    .mclk           (mclk),
    .resetn         (resetn),
    .shiftClockRise (sclkRise),
    .frameSelectN   (frameSelectN),
    .shiftIn        (shiftIn),
    .partial        (partial),
    .bitCount       (bitCount),
    .frameDone      (frameDone),
    .frameWord      (frameWord)
  );

  assign wrAddr = frameWord[acr_pkg::FRAME_W-1:acr_pkg::DATA_W]; // [RULE20]
  assign wrData = frameWord[acr_pkg::DATA_W-1:0];

  // Address completes on the eighth rising edge of the frame
  assign rdAddr = {partial[acr_pkg::ADDR_W-2:0], shiftIn};
  assign rdLoad = sclkRise & ~frameSelectN &
                  (bitCount == 5'(acr_pkg::ADDR_W - 1));

  // Readback mux; register 0 is write-only and reads as zero
  always_comb begin
    case (rdAddr)
      acr_pkg::ADDR_PWR:  rdData = pwr_q & acr_pkg::MASK_PWR;   // [RULE22]
      acr_pkg::ADDR_LANE: rdData = lane_q & acr_pkg::MASK_LANE; // [RULE22]
      default:            rdData = '0; // [RULE7]
    endcase
  end

  // Readback serializer, pin driven only in readback mode
  acr_read_out u_read (
    .mclk           (mclk),
    .resetn         (resetn),
    .shiftClockFall (sclkFall),
    .load           (rdLoad & ctrl_q[acr_pkg::B_RDSEL]),
    .loadData       (rdData),
    .enable         (ctrl_q[acr_pkg::B_RDSEL]),
    .dataOut        (serialReadOut),
    .dataOutEnN     (serialReadOutEnN)
  );

  // Register update and software init sequencing
  always_comb begin
    st_d   = st_q;
    ctrl_d = ctrl_q;
    pwr_d  = pwr_q;
    lane_d = lane_q;
    case (st_q)
      ACR_RUN: begin
        if (pinPulse) begin // [RULE1]
          ctrl_d = acr_pkg::REG_RESET; // [RULE4]
          pwr_d  = acr_pkg::REG_RESET;
          lane_d = acr_pkg::REG_RESET;
        end else if (frameDone) begin
          if (wrAddr == acr_pkg::ADDR_CTRL) begin
            // Register 0 always writable, even in readback mode
            ctrl_d = wrData; // [RULE7]
            if (wrData[acr_pkg::B_INIT]) begin
              st_d = ACR_INIT; // [RULE2]
            end
          end else if (!ctrl_q[acr_pkg::B_RDSEL]) begin // [RULE8]
            if (wrAddr == acr_pkg::ADDR_PWR) begin
              pwr_d = wrData;
            end else if (wrAddr == acr_pkg::ADDR_LANE) begin
              lane_d = wrData;
            end
          end
        end
      end
      ACR_INIT: begin
        // Load defaults, which also clears the init bit itself
        ctrl_d = acr_pkg::REG_RESET; // [RULE2]
        pwr_d  = acr_pkg::REG_RESET; // [RULE4]
        lane_d = acr_pkg::REG_RESET;
        st_d   = ACR_RUN;
      end
      default: begin
        st_d = ACR_RUN;
      end
    endcase
  end

  // Registers only
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_q   <= ACR_RUN;
      ctrl_q <= acr_pkg::REG_RESET; // [RULE4]
      pwr_q  <= acr_pkg::REG_RESET;
      lane_q <= acr_pkg::REG_RESET;
    end else begin
      st_q   <= st_d;
      ctrl_q <= ctrl_d;
      pwr_q  <= pwr_d;
      lane_q <= lane_d;
    end
  end

  // Field outputs straight from flip-flops
  assign readbackSelect       = ctrl_q[acr_pkg::B_RDSEL];
  assign fullSleep            = pwr_q[acr_pkg::B_FULL_SLEEP];   // [RULE9]
  assign serialOutOff         = pwr_q[acr_pkg::B_SEROUT_OFF];   // [RULE10]
  assign lightSleep           = pwr_q[acr_pkg::B_LIGHT_SLEEP];  // [RULE12]
  assign slowNoiseReject      = pwr_q[acr_pkg::B_SLOW_NR];      // [RULE13]
  assign outsideVoltageSource = pwr_q[acr_pkg::B_OUTSIDE_REF];  // [RULE14]
  assign pairSharing          = pwr_q[acr_pkg::B_PAIR_SHARE];   // [RULE15]
  assign oneWireClockInput    = pwr_q[acr_pkg::B_ONE_WIRE_CLK]; // [RULE16]
  assign channelPairMean      = lane_q[acr_pkg::B_PAIR_MEAN];   // [RULE18]
  assign fastPathBypass       = lane_q[acr_pkg::B_FAST_PATH];   // [RULE19]

  // Per-channel bit maps, channel 1 at the low field bit
  for (genvar i = 0; i < acr_pkg::NCH; i++) begin : g_ch
    assign perChannelConverterOff[i] =
      pwr_q[acr_pkg::B_CHOFF_LO + i]; // [RULE11]
    assign perLaneDriverOff[i] =
      lane_q[acr_pkg::B_LANEOFF_LO + i]; // [RULE17]
  end
endmodule // acr_top

/* File: verification/acr_host_model.sv */
// Host controller model driving the three-wire serial port
`timescale 1ns/100ps
module acr_host_model (
  input  wire logic mclk,
  input  wire logic serialReadOut,
  input  wire logic serialReadOutEnN,
  output logic      shiftClock,
  output logic      frameSelectN,
  output logic      shiftIn
);
  localparam int HALF = 8; // Mclk cycles per high shift clock phase, low phase lasts one more
  // A released readback line shows the inverse of its last value
  wire logic rdLine = serialReadOutEnN ? ~serialReadOut : serialReadOut;
  initial begin
    shiftClock = 1'b0; // Stands still low between frames
    frameSelectN = 1'b1;
    shiftIn = 1'b0; // Pulled down while idle
  end
  // Sends nb bits MSB first, collects readback before the falls of bits 8 to 23 of each frame
  task automatic xfer(input int nb, input logic [47:0] w,
                      output logic [15:0] rd);
    rd = 16'h0000;
    @(posedge mclk) frameSelectN <= 1'b0;
    for (int i = 0; i < nb; i++) begin
      @(posedge mclk) shiftIn <= w[nb-1-i];
      repeat (HALF) @(posedge mclk);
      shiftClock <= 1'b1;
      repeat (HALF) @(posedge mclk);
      if (i % 24 >= 7 && i % 24 < 23) rd = {rd[14:0], rdLine};
      shiftClock <= 1'b0;
    end
    repeat (HALF) @(posedge mclk);
    frameSelectN <= 1'b1;
    shiftIn <= 1'b0;
  endtask
endmodule // acr_host_model

/* File: verification/acr_top_asserts.sv */
// Port checker for the converter control register bank
`timescale 1ns/100ps
module acr_top_asserts (
  input wire logic                    mclk,
  input wire logic                    resetn,
  input wire logic                    resetPin,
  input wire logic                    shiftClock,
  input wire logic                    frameSelectN,
  input wire logic                    serialReadOutEnN,
  input wire logic                    fullSleep,
  input wire logic                    serialOutOff,
  input wire logic [acr_pkg::NCH-1:0] perChannelConverterOff,
  input wire logic                    lightSleep,
  input wire logic                    slowNoiseReject,
  input wire logic                    outsideVoltageSource,
  input wire logic                    pairSharing,
  input wire logic                    oneWireClockInput,
  input wire logic [acr_pkg::NCH-1:0] perLaneDriverOff,
  input wire logic                    channelPairMean,
  input wire logic                    fastPathBypass,
  input wire logic                    readbackSelect
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // Every register-driven output in one vector
  wire logic [25:0] cfgAll = {readbackSelect, fullSleep, serialOutOff,
    perChannelConverterOff, lightSleep, slowNoiseReject,
    outsideVoltageSource, pairSharing, oneWireClockInput,
    perLaneDriverOff, channelPairMean, fastPathBypass};
  logic [4:0] selHist_q; // Recent frame select samples
  logic [4:0] pinHist_q; // Recent reset pin samples
  logic [3:0] riseAge_q; // Cycles since a shift clock rise, saturating
  logic       clkPrev_q; // Shift clock one cycle ago
  // Pin activity masks write checks, the clear may lag the pin
  wire logic  quiet = !(|pinHist_q) && !resetPin;
  // History of select, pin and shift clock
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      selHist_q <= 5'h1f;
      pinHist_q <= 5'h00;
      riseAge_q <= 4'hf;
      clkPrev_q <= 1'b0;
    end else begin
      selHist_q <= {selHist_q[3:0], frameSelectN};
      pinHist_q <= {pinHist_q[3:0], resetPin};
      clkPrev_q <= shiftClock;
      riseAge_q <= (shiftClock && !clkPrev_q) ? 4'h0 :
                   riseAge_q + {3'h0, riseAge_q != 4'hf};
    end
  end
  property p_reset_vals;
    $rose(resetn) |-> cfgAll == 26'h0 && serialReadOutEnN;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("Outputs not at default after reset");
  property p_pin_clear;
    $fell(resetPin) |-> ##[1:2] cfgAll == 26'h0;
  endproperty
  a_pin_clear: assert property (p_pin_clear)
    else $error("Reset pin pulse did not clear registers");
  property p_rd_enable;
    serialReadOutEnN == !$past(readbackSelect);
  endproperty
  a_rd_enable: assert property (p_rd_enable)
    else $error("Readback drive not following select");
  property p_en_rise;
    $rose(readbackSelect) |-> serialReadOutEnN ##1 !serialReadOutEnN;
  endproperty
  a_en_rise: assert property (p_en_rise)
    else $error("Readback drive late after select set");
  property p_en_fall;
    $fell(readbackSelect) |-> !serialReadOutEnN ##1 serialReadOutEnN;
  endproperty
  a_en_fall: assert property (p_en_fall)
    else $error("Readback drive kept after select cleared");
  property p_read_hold;
    readbackSelect && $past(readbackSelect) |-> $stable(cfgAll);
  endproperty
  a_read_hold: assert property (p_read_hold)
    else $error("Register written while in read mode");
  property p_select_idle;
    frameSelectN && (&selHist_q) && quiet |-> $stable(cfgAll);
  endproperty
  a_select_idle: assert property (p_select_idle)
    else $error("Register changed with frame select high");
  property p_after_rise;
    !$stable(cfgAll) && quiet |-> riseAge_q <= 4'ha;
  endproperty
  a_after_rise: assert property (p_after_rise)
    else $error("Register changed away from a shift clock rise");
  c_read: cover property ($rose(readbackSelect));
  c_pin: cover property ($fell(resetPin));
  c_write: cover property (!$stable(cfgAll) && quiet);
endmodule // acr_top_asserts
bind acr_top acr_top_asserts u_acr_top_asserts (.mclk, .resetn, .resetPin,
  .shiftClock, .frameSelectN, .serialReadOutEnN, .fullSleep, .serialOutOff,
  .perChannelConverterOff, .lightSleep, .slowNoiseReject,
  .outsideVoltageSource, .pairSharing, .oneWireClockInput, .perLaneDriverOff,
  .channelPairMean, .fastPathBypass, .readbackSelect);

/* File: verification/acr_top_test.sv */
// Self-checking bench for the converter control register bank
`timescale 1ns/100ps
module acr_top_test;
  logic                    mclk = 1'b0;
  logic                    resetn = 1'b0;
  logic                    resetPin = 1'b0; // Low outside pin
  wire logic               shiftClock, frameSelectN, shiftIn;
  logic                    serialReadOut, serialReadOutEnN, readbackSelect;
  logic                    fullSleep, serialOutOff, lightSleep;
  logic                    slowNoiseReject, outsideVoltageSource;
  logic                    pairSharing, oneWireClockInput;
  logic                    channelPairMean, fastPathBypass;
  logic [acr_pkg::NCH-1:0] perChannelConverterOff, perLaneDriverOff;
  logic [15:0]             e1, e2, d, rd; // Expected registers, scratch
  logic [31:0]             rngState = 32'h6b97a18f;
  int                      mismatches = 0;
  int                      checksDone = 0;
  int                      cycles = 0;
  // Ports gathered back into register layout
  wire logic [15:0] obs1 = {oneWireClockInput, pairSharing,
    outsideVoltageSource, 1'b0, slowNoiseReject, lightSleep,
    perChannelConverterOff, serialOutOff, fullSleep};
  wire logic [15:0] obs2 = {3'h0, fastPathBypass, channelPairMean,
    perLaneDriverOff, 3'h0};
  initial forever #25 mclk = ~mclk;
  acr_top u_acr_top (.mclk, .resetn, .resetPin, .shiftClock, .frameSelectN,
    .shiftIn, .serialReadOut, .serialReadOutEnN, .fullSleep, .serialOutOff,
    .perChannelConverterOff, .lightSleep, .slowNoiseReject,
    .outsideVoltageSource, .pairSharing, .oneWireClockInput,
    .perLaneDriverOff, .channelPairMean, .fastPathBypass, .readbackSelect);
  acr_host_model u_acr_host_model (.mclk, .serialReadOut, .serialReadOutEnN,
    .shiftClock, .frameSelectN, .shiftIn);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // Host keeps unlisted bits zero, so these are also the readback values
  function automatic logic [15:0] fld(input logic [7:0] a,
                                      input logic [15:0] v);
    return (a == acr_pkg::ADDR_PWR) ? v & acr_pkg::MASK_PWR :
           (a == acr_pkg::ADDR_LANE) ? v & acr_pkg::MASK_LANE : 16'h0000;
  endfunction
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    checksDone++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checksDone, mismatches);
    if (mismatches == 0 && checksDone > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Frame plus settling time for the commit
  task automatic frame(input int nb, input logic [47:0] w);
    u_acr_host_model.xfer(nb, w, rd);
    repeat (4) @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    frame(24, {24'h0, a, v});
  endtask
  task automatic regs(input string t);
    check("r1", obs1, e1);
    check("r2", obs2, e2);
    $display("%s done", t);
  endtask
  // Hang guard, far above the expected run length
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      mismatches++;
      close_out();
    end
  end
  initial begin
    e1 = 16'h0000;
    e2 = 16'h0000;
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    regs("reset");
    check("rdEnN", {15'h0, serialReadOutEnN}, 16'h0001);
    // Random writes, all-ones corner first
    for (int k = 0; k < 6; k++) begin
      rngState = xs(rngState);
      d = (k == 0) ? 16'hffff : rngState[15:0];
      e1 = fld(acr_pkg::ADDR_PWR, d);
      e2 = fld(acr_pkg::ADDR_LANE, rngState[31:16] | d);
      wr(acr_pkg::ADDR_PWR, e1);
      wr(acr_pkg::ADDR_LANE, e2);
      check("r1", obs1, e1);
      check("r2", obs2, e2);
    end
    $display("random writes done");
    // Back-to-back frames, a short one, excess bits, an unmapped place
    rngState = xs(rngState);
    e1 = fld(acr_pkg::ADDR_PWR, rngState[15:0]);
    e2 = fld(acr_pkg::ADDR_LANE, rngState[31:16]);
    frame(48, {acr_pkg::ADDR_PWR, e1, acr_pkg::ADDR_LANE, e2});
    check("r1", obs1, e1);
    frame(12, {36'h0, acr_pkg::ADDR_PWR, 4'h5});
    e2 = fld(acr_pkg::ADDR_LANE, ~e2);
    frame(30, {18'h0, acr_pkg::ADDR_LANE, e2, 6'h3f});
    wr(8'h05, 16'h1234);
    regs("frames");
    // Read mode: reads of each place, data bits must not land
    wr(acr_pkg::ADDR_CTRL, 16'h0002);
    check("rdSel", {15'h0, readbackSelect}, 16'h0001);
    check("rdEnN", {15'h0, serialReadOutEnN}, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      rngState = xs(rngState);
      d = (k == 0) ? 16'h0002 : rngState[15:0];
      frame(24, {24'h0, 6'h0, k[1:0], d});
      // Undefined positions and unreadable places must shift out zero
      check("rsv", rd & ~(k == 1 ? acr_pkg::MASK_PWR : k == 2 ?
        acr_pkg::MASK_LANE : 16'h0000), 16'h0000);
      check("rd", rd, k == 1 ? e1 : k == 2 ? e2 : 16'h0000);
    end
    regs("readback");
    wr(acr_pkg::ADDR_CTRL, 16'h0000);
    check("rdEnN", {15'h0, serialReadOutEnN}, 16'h0001);
    // Software init with the pin left low
    wr(acr_pkg::ADDR_CTRL, 16'h0003);
    e1 = 16'h0000;
    e2 = 16'h0000;
    check("rdSel", {15'h0, readbackSelect}, 16'h0000);
    regs("soft init");
    // Hardware pin pulse
    e1 = 16'h8001;
    e2 = 16'h1000;
    wr(acr_pkg::ADDR_PWR, e1);
    wr(acr_pkg::ADDR_LANE, e2);
    check("r1", obs1, e1);
    resetPin <= 1'b1;
    repeat (3) @(posedge mclk);
    resetPin <= 1'b0;
    repeat (3) @(posedge mclk);
    e1 = 16'h0000;
    e2 = 16'h0000;
    regs("pin reset");
    close_out();
  end
endmodule // acr_top_test
